// >>> hw/jaio_defines.svh
`ifndef JAIO_DEFINES_SVH
`define JAIO_DEFINES_SVH

// port widths
`define JAIO_NGPI 4
`define JAIO_NGPO 4
`define JAIO_NSYNC 8

// positions in the synchroniser bank
`define JAIO_SY_START 4
`define JAIO_SY_AUX 5
`define JAIO_SY_RRST 6
`define JAIO_SY_ABORT 7

// positions in the wait selection
`define JAIO_WS_START 4
`define JAIO_WS_AUX 5

// fields of an instruction argument
`define JAIO_ARG_IDX_MSB 1
`define JAIO_ARG_IDX_LSB 0
`define JAIO_ARG_VAL 2
`define JAIO_ARG_TRIG_MAIN 0
`define JAIO_ARG_TRIG_AUX 1

// reset values
`define JAIO_GPO_RST 4'h0
`define JAIO_WSEL_RST 6'h00
`define JAIO_EDGE_RST 4'h0

`endif

// >>> hw/jaio_pkg.sv
`include "jaio_defines.svh"

package jaio_pkg;

  typedef enum logic [2:0] {
    OP_NOP       = 3'h0,
    OP_JOB_OPEN  = 3'h1,
    OP_JOB_CLOSE = 3'h2,
    OP_MARK_ON   = 3'h3,
    OP_MARK_OFF  = 3'h4,
    OP_SET_GPO   = 3'h5,
    OP_WAIT_GPI  = 3'h6,
    OP_WAIT_TRIG = 3'h7
  } jaio_op_t;

  typedef struct packed {
    jaio_op_t op;
    logic [3:0] arg;
  } jaio_instr_t;

  typedef struct packed {
    logic [`JAIO_NGPI-1:0] gpi_invert;
    logic [`JAIO_NGPI-1:0] gpi_edge;
    logic [`JAIO_NGPO-1:0] gpo_invert;
  } jaio_cfg_t;

  typedef struct packed {
    logic start;
    logic aux_start;
    logic remote_reset;
    logic abort;
  } jaio_sync_in_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_WAIT = 2'b10
  } jaio_state_t;

endpackage

// >>> hw/jaio_sync.sv
`timescale 1ns/1ps
`default_nettype none

module jaio_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // meta feeds only q
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // jaio_sync

`default_nettype wire

// >>> hw/jaio_top.sv
// Summary of operation
// RL1: Four general inputs each have own polarity and level or edge mode.
// RL2: A wait holds the job until any selected general input is asserted.
// RL3: Four general outputs have own polarity; an instruction sets any one.
// RL4: Four status outputs: busy, marking, fault-or-ready, job pending.
// RL5: Busy rises when job-open executes and falls when job-close executes.
// RL6: Marking active is high exactly while marking is in progress.
// RL7: Active-low fault-or-ready is low on error and high when ready.
// RL8: Job pending is high while a job is active, also while it waits.
// RL9: A wait may hold the job until the auxiliary start input is asserted.
// RL10: A wait may hold the job until the main start input is asserted.
// RL11: A rising remote reset input soft-resets and re-initialises the block.
// RL12: The abort input makes job control drop the job and return to idle.
// RL13: Every general input and sync pin passes two flip-flops before any logic uses it.
`timescale 1ns/1ps
`default_nettype none
`include "jaio_defines.svh"

module jaio_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [`JAIO_NGPI-1:0] general_inputs,
  input wire jaio_pkg::jaio_sync_in_t sync_pins,
  input wire jaio_pkg::jaio_cfg_t cfg,
  input wire logic instr_valid,
  input wire jaio_pkg::jaio_instr_t instr,
  input wire logic job_loaded,
  input wire logic error_event,
  input wire logic error_clear,
  output logic instr_ready,
  output logic [`JAIO_NGPO-1:0] general_outputs,
  output logic busy_out,
  output logic marking_active_out,
  output logic fault_ready_n_out,
  output logic job_pending_out,
  output logic [`JAIO_NGPI-1:0] gpi_status,
  output logic soft_reset_out
);

  logic [`JAIO_NSYNC-1:0] raw_in;
  logic [`JAIO_NSYNC-1:0] sy;
  logic [`JAIO_NGPI-1:0] gpi_adj;
  logic [`JAIO_NGPI-1:0] gpi_adj_q;
  logic [`JAIO_NGPI-1:0] edge_seen;
  logic [`JAIO_NGPI-1:0] gpi_hit;
  logic start_lvl;
  logic aux_lvl;
  logic rrst_lvl;
  logic rrst_q;
  logic abort_lvl;
  logic soft_pulse;
  jaio_pkg::jaio_state_t state;
  jaio_pkg::jaio_state_t next_state;
  logic [5:0] wait_sel;
  logic [5:0] next_wait_sel;
  logic [5:0] wait_src;
  logic wait_done;
  logic accept;
  logic [`JAIO_NGPO-1:0] gpo_level;
  logic [`JAIO_NGPO-1:0] next_gpo_level;
  logic next_marking;
  logic [1:0] set_idx;
  logic set_val;

  function automatic logic [`JAIO_NGPI-1:0] gpi_fire(
    input logic [`JAIO_NGPI-1:0] edge_mode,
    input logic [`JAIO_NGPI-1:0] level,
    input logic [`JAIO_NGPI-1:0] edges
  );
    gpi_fire = (edge_mode & edges) | (~edge_mode & level);
  endfunction

  function automatic logic is_op(
    input jaio_pkg::jaio_instr_t i,
    input jaio_pkg::jaio_op_t op
  );
    is_op = (i.op == op);
  endfunction

  assign raw_in = {sync_pins.abort, sync_pins.remote_reset,
                   sync_pins.aux_start, sync_pins.start, general_inputs};

  jaio_sync #(
    .W(`JAIO_NSYNC)
  ) u_sync ( // RL13
    .clk(clk),
    .nrst(nrst),
    .d(raw_in),
    .q(sy)
  );

  assign gpi_adj = sy[`JAIO_NGPI-1:0] ^ cfg.gpi_invert; // RL1
  assign start_lvl = sy[`JAIO_SY_START];
  assign aux_lvl = sy[`JAIO_SY_AUX];
  assign rrst_lvl = sy[`JAIO_SY_RRST];
  assign abort_lvl = sy[`JAIO_SY_ABORT];
  assign gpi_hit = gpi_fire(cfg.gpi_edge, gpi_adj, edge_seen); // RL1
  assign wait_src = {aux_lvl, start_lvl, gpi_hit};
  assign wait_done = |(wait_sel & wait_src); // RL2 RL9 RL10
  assign accept = instr_valid && instr_ready;
  assign set_idx = instr.arg[`JAIO_ARG_IDX_MSB:`JAIO_ARG_IDX_LSB];
  assign set_val = instr.arg[`JAIO_ARG_VAL];

  // remote reset acts on its rising edge so a held level resets once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rrst_q <= 1'b0;
      soft_pulse <= 1'b0;
      soft_reset_out <= 1'b0;
    end else begin
      rrst_q <= rrst_lvl;
      soft_pulse <= rrst_lvl && !rrst_q; // RL11
      soft_reset_out <= rrst_lvl && !rrst_q;
    end
  end

  // flipping gpi_invert looks like an edge; set polarity before waiting
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gpi_adj_q <= `JAIO_EDGE_RST;
      edge_seen <= `JAIO_EDGE_RST;
      gpi_status <= `JAIO_EDGE_RST;
    end else begin
      gpi_adj_q <= gpi_adj;
      gpi_status <= gpi_adj; // RL1
      for (int i = 0; i < `JAIO_NGPI; i++) begin
        if (gpi_adj[i] && !gpi_adj_q[i]) begin
          edge_seen[i] <= 1'b1; // RL1
        end else if (soft_pulse ||
                     (accept && is_op(instr, jaio_pkg::OP_WAIT_GPI))) begin
          edge_seen[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    next_state = state;
    next_wait_sel = wait_sel;
    unique case (state)
      jaio_pkg::ST_IDLE: begin
        if (accept && is_op(instr, jaio_pkg::OP_JOB_OPEN)) begin
          next_state = jaio_pkg::ST_RUN; // RL5
        end
      end
      jaio_pkg::ST_RUN: begin
        if (accept) begin
          unique case (instr.op)
            jaio_pkg::OP_JOB_CLOSE: next_state = jaio_pkg::ST_IDLE; // RL5
            jaio_pkg::OP_WAIT_GPI: begin
              next_state = jaio_pkg::ST_WAIT; // RL2
              next_wait_sel = {2'b00, instr.arg};
            end
            jaio_pkg::OP_WAIT_TRIG: begin
              next_state = jaio_pkg::ST_WAIT;
              next_wait_sel = `JAIO_WSEL_RST;
              next_wait_sel[`JAIO_WS_START] =
                instr.arg[`JAIO_ARG_TRIG_MAIN]; // RL10
              next_wait_sel[`JAIO_WS_AUX] =
                instr.arg[`JAIO_ARG_TRIG_AUX]; // RL9
            end
            default: next_state = jaio_pkg::ST_RUN;
          endcase
        end
      end
      jaio_pkg::ST_WAIT: begin
        if (wait_done) begin
          next_state = jaio_pkg::ST_RUN; // RL2
        end
      end
      default: next_state = jaio_pkg::ST_IDLE;
    endcase
    if (abort_lvl || soft_pulse) begin
      next_state = jaio_pkg::ST_IDLE; // RL12
      next_wait_sel = `JAIO_WSEL_RST;
    end
  end

  // a wait with an empty selection never resumes; only abort or a soft reset frees it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= jaio_pkg::ST_IDLE;
      wait_sel <= `JAIO_WSEL_RST;
      instr_ready <= 1'b0;
    end else begin
      state <= next_state;
      wait_sel <= next_wait_sel;
      instr_ready <= (next_state != jaio_pkg::ST_WAIT) && !abort_lvl;
    end
  end

  always_comb begin
    next_gpo_level = gpo_level;
    next_marking = marking_active_out;
    if (accept && state == jaio_pkg::ST_RUN) begin
      if (is_op(instr, jaio_pkg::OP_SET_GPO)) begin
        next_gpo_level[set_idx] = set_val; // RL3
      end
      if (is_op(instr, jaio_pkg::OP_MARK_ON)) begin
        next_marking = 1'b1; // RL6
      end
      if (is_op(instr, jaio_pkg::OP_MARK_OFF)) begin
        next_marking = 1'b0;
      end
    end
    if (next_state == jaio_pkg::ST_IDLE) begin
      next_marking = 1'b0; // RL6
    end
    if (soft_pulse) begin
      next_gpo_level = `JAIO_GPO_RST; // RL11
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gpo_level <= `JAIO_GPO_RST;
      general_outputs <= `JAIO_GPO_RST;
    end else begin
      gpo_level <= next_gpo_level;
      general_outputs <= next_gpo_level ^ cfg.gpo_invert; // RL3
    end
  end

  // status outputs, each straight from its own flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_out <= 1'b0;
      marking_active_out <= 1'b0;
      job_pending_out <= 1'b0;
    end else begin
      busy_out <= next_state != jaio_pkg::ST_IDLE; // RL4 RL5
      marking_active_out <= next_marking; // RL4 RL6
      job_pending_out <= (next_state != jaio_pkg::ST_IDLE) ||
                         (job_loaded && !abort_lvl); // RL4 RL8
    end
  end

  // a new error wins over a clear in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_ready_n_out <= 1'b1;
    end else if (error_event) begin
      fault_ready_n_out <= 1'b0; // RL4 RL7
    end else if (error_clear || soft_pulse) begin
      fault_ready_n_out <= 1'b1;
    end
  end

  logic set_tgt;
  assign set_tgt = set_val ^ cfg.gpo_invert[set_idx];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_busy_open: assert property ( // RL5
    accept && state == jaio_pkg::ST_IDLE && is_op(instr, jaio_pkg::OP_JOB_OPEN)
    && !abort_lvl && !soft_pulse |=> busy_out && job_pending_out)
    else $error("busy not raised by job open");

  a_busy_close: assert property ( // RL5
    accept && state == jaio_pkg::ST_RUN
    && is_op(instr, jaio_pkg::OP_JOB_CLOSE) |=> !busy_out)
    else $error("busy not dropped by job close");

  a_mark_in_job: assert property ( // RL6
    marking_active_out |-> busy_out)
    else $error("marking shown outside a job");

  a_fault_set: assert property ( // RL7
    error_event |=> !fault_ready_n_out)
    else $error("fault not shown after error");

  a_pending_job: assert property ( // RL8
    state == jaio_pkg::ST_WAIT |-> job_pending_out && busy_out)
    else $error("pending low during active job");

  a_wait_hold: assert property ( // RL2
    state == jaio_pkg::ST_WAIT && !wait_done && !abort_lvl && !soft_pulse
    |=> state == jaio_pkg::ST_WAIT && !instr_ready)
    else $error("wait left without a source");

  a_wait_main: assert property ( // RL10
    state == jaio_pkg::ST_WAIT && wait_sel[`JAIO_WS_START] && start_lvl
    && !abort_lvl && !soft_pulse |=> state == jaio_pkg::ST_RUN && instr_ready)
    else $error("main start did not resume job");

  a_wait_aux: assert property ( // RL9
    state == jaio_pkg::ST_WAIT && wait_sel[`JAIO_WS_AUX] && aux_lvl
    && !abort_lvl && !soft_pulse |=> state == jaio_pkg::ST_RUN)
    else $error("aux start did not resume job");

  a_gpo_set: assert property ( // RL3
    accept && state == jaio_pkg::ST_RUN && is_op(instr, jaio_pkg::OP_SET_GPO)
    && !soft_pulse |=> general_outputs[$past(set_idx)] == $past(set_tgt))
    else $error("general output not set");

  a_abort_idle: assert property ( // RL12
    abort_lvl |=> !busy_out && !marking_active_out && !instr_ready)
    else $error("abort did not idle the job");

  a_soft_reinit: assert property ( // RL11
    $rose(rrst_lvl) |=> soft_pulse ##1 !busy_out
    && gpo_level == `JAIO_GPO_RST && edge_seen == `JAIO_EDGE_RST)
    else $error("soft reset did not re-initialise");

  a_sync_depth: assert property ( // RL13 RL1
    $stable(cfg.gpi_invert) [*3]
    |-> gpi_status == ($past(general_inputs, 3) ^ cfg.gpi_invert))
    else $error("general input not seen after two stages");

  c_job_open: cover property (
    state == jaio_pkg::ST_IDLE ##1 state == jaio_pkg::ST_RUN);
  c_wait_done: cover property (
    state == jaio_pkg::ST_WAIT ##1 state == jaio_pkg::ST_RUN);
  c_abort_job: cover property (busy_out && abort_lvl);
  c_soft_reset: cover property (soft_pulse && busy_out);

endmodule // jaio_top

`default_nettype wire

// >>> verification/jaio_equip.sv
`timescale 1ns/1ps
`default_nettype none

// factory equipment: pulses the selected lines after a chosen delay
module jaio_equip (
  input wire logic clk,
  input wire logic fire,
  input wire logic [7:0] sel,
  input wire logic [3:0] gap,
  output logic [3:0] general_inputs,
  output jaio_pkg::jaio_sync_in_t sync_pins
);
  // released lines go back to inactive, the isolator idles low
  logic [7:0] drv = 8'h00;

  assign general_inputs = drv[3:0];
  assign sync_pins = jaio_pkg::jaio_sync_in_t'(drv[7:4]);

  // gap 0 answers at once, larger gaps model a slow operator
  always @(posedge fire) begin
    repeat (gap) @(negedge clk);
    drv = sel;
    repeat (4) @(negedge clk);
    drv = 8'h00;
  end
endmodule // jaio_equip

`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic instr_valid = 1'b0;
  jaio_pkg::jaio_instr_t instr = '0;
  jaio_pkg::jaio_cfg_t cfg = '0;
  logic job_loaded = 1'b0;
  logic error_event = 1'b0;
  logic error_clear = 1'b0;
  logic fire = 1'b0;
  logic [7:0] sel = 8'h00;
  logic [3:0] gap = 4'h0;
  logic [3:0] gpi;
  jaio_pkg::jaio_sync_in_t pins;
  logic instr_ready, busy, marking, fault_n, pending, soft_rst;
  logic [3:0] gpo, gpi_status, st;
  int num_errors = 0;
  int check_count = 0;

  assign st = {busy, marking, fault_n, pending};

  initial begin
    forever #2.5 clk = ~clk;
  end

  jaio_equip equip (.clk(clk), .fire(fire), .sel(sel), .gap(gap),
    .general_inputs(gpi), .sync_pins(pins));

  jaio_top DUT (.clk(clk), .nrst(nrst), .general_inputs(gpi),
    .sync_pins(pins), .cfg(cfg), .instr_valid(instr_valid),
    .instr(instr), .job_loaded(job_loaded), .error_event(error_event),
    .error_clear(error_clear), .instr_ready(instr_ready),
    .general_outputs(gpo), .busy_out(busy),
    .marking_active_out(marking), .fault_ready_n_out(fault_n),
    .job_pending_out(pending), .gpi_status(gpi_status),
    .soft_reset_out(soft_rst));

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_ready(input int lim);
    for (int n = 0; instr_ready !== 1'b1; n++) begin
      if (n >= lim) begin
        num_errors++;
        $display("[ERR] t=%0t ready got=%h exp=%h", $time, instr_ready, 1'b1);
        tally_and_finish();
      end
      @(negedge clk);
    end
  endtask

  task automatic issue(input jaio_pkg::jaio_op_t op, input logic [3:0] arg);
    // an idle edge first, so valid is never re-raised in the step it fell
    @(negedge clk);
    wait_ready(20);
    instr_valid = 1'b1;
    instr.op = op;
    instr.arg = arg;
    @(negedge clk);
    instr_valid = 1'b0;
  endtask

  task automatic press(input logic [7:0] s, input logic [3:0] g);
    sel = s;
    gap = g;
    fire = 1'b1;
    @(negedge clk);
    fire = 1'b0;
  endtask

  // a wrong source must not release the wait, the right one must
  task automatic wait_case(input jaio_pkg::jaio_op_t op,
      input logic [3:0] arg, input logic [7:0] wrong, input logic [7:0] right);
    issue(op, arg);
    check_bit(instr_ready, 1'b0);
    check(st, 4'b1011);
    press(wrong, 4'h0);
    repeat (8) @(negedge clk);
    check_bit(instr_ready, 1'b0);
    press(right, 4'h9);
    wait_ready(20);
    repeat (6) @(negedge clk);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("[ERR] t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end

  initial begin
    int hits;
    hits = 0;
    repeat (5) @(negedge clk);
    check(st, 4'b0010);
    nrst = 1'b1;
    @(negedge clk);
    issue(jaio_pkg::OP_JOB_OPEN, 4'h0);
    check(st, 4'b1011);
    issue(jaio_pkg::OP_MARK_ON, 4'h0);
    check(st, 4'b1111);
    issue(jaio_pkg::OP_MARK_OFF, 4'h0);
    check(st, 4'b1011);
    for (int k = 0; k < 4; k++) begin
      issue(jaio_pkg::OP_SET_GPO, {2'b01, k[1:0]});
      check(gpo, 4'((1 << (k + 1)) - 1));
    end
    cfg.gpo_invert = 4'h5;
    @(negedge clk);
    check(gpo, 4'ha);
    issue(jaio_pkg::OP_SET_GPO, 4'h1);
    check(gpo, 4'h8);
    cfg.gpo_invert = 4'h0;
    cfg.gpi_invert = 4'hf;
    repeat (2) @(negedge clk);
    check(gpi_status, 4'hf);
    cfg.gpi_invert = 4'h0;
    repeat (2) @(negedge clk);
    press(8'h03, 4'h0);
    @(negedge clk);
    check(gpi_status, 4'h0);
    @(negedge clk);
    check(gpi_status, 4'h3);
    repeat (4) @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      wait_case(jaio_pkg::OP_WAIT_GPI, 4'h1 << k, 8'h01 << ((k + 1) % 4),
        8'h01 << k);
    end
    // edge mode: a line already high when the wait starts must not count
    cfg.gpi_edge = 4'h1;
    press(8'h01, 4'h0);
    repeat (3) @(negedge clk);
    wait_case(jaio_pkg::OP_WAIT_GPI, 4'h1, 8'h02, 8'h01);
    cfg.gpi_edge = 4'h0;
    wait_case(jaio_pkg::OP_WAIT_TRIG, 4'h1, 8'h40, 8'h80);
    wait_case(jaio_pkg::OP_WAIT_TRIG, 4'h2, 8'h80, 8'h40);
    error_event = 1'b1;
    @(negedge clk);
    error_event = 1'b0;
    check_bit(fault_n, 1'b0);
    @(negedge clk);
    check_bit(fault_n, 1'b0);
    error_clear = 1'b1;
    @(negedge clk);
    error_clear = 1'b0;
    check_bit(fault_n, 1'b1);
    job_loaded = 1'b1;
    issue(jaio_pkg::OP_JOB_CLOSE, 4'h0);
    check(st, 4'b0011);
    job_loaded = 1'b0;
    issue(jaio_pkg::OP_JOB_OPEN, 4'h0);
    issue(jaio_pkg::OP_MARK_ON, 4'h0);
    press(8'h10, 4'h0);
    for (int n = 0; n < 10 && busy !== 1'b0; n++) begin
      @(negedge clk);
    end
    check(st, 4'b0010);
    check_bit(instr_ready, 1'b0);
    wait_ready(20);
    repeat (4) @(negedge clk);
    issue(jaio_pkg::OP_JOB_OPEN, 4'h0);
    issue(jaio_pkg::OP_SET_GPO, 4'h4);
    // abort leaves the outputs alone; only a soft reset clears them
    check(gpo, 4'hd);
    // a clear in the same cycle as a new error loses
    error_event = 1'b1;
    error_clear = 1'b1;
    @(negedge clk);
    error_event = 1'b0;
    error_clear = 1'b0;
    check_bit(fault_n, 1'b0);
    press(8'h20, 4'h0);
    for (int n = 0; n < 8; n++) begin
      @(negedge clk);
      if (soft_rst === 1'b1) begin
        hits++;
      end
    end
    check(4'(hits), 4'h1);
    check(gpo, 4'h0);
    check(st, 4'b0010);
    tally_and_finish();
  end
endmodule // testbench

`default_nettype wire
